// File: design/nvb_pkg.sv
/*
 * Package for the byte-access controller of a 512-byte nonvolatile array:
 * register indices, field positions, reset values and timing counts.
 * Assumes a single 125 MHz clock shared by both ends of the register link.
 */
package nvb_pkg;
    // Array geometry
    localparam int unsigned ARRAY_BYTES = 512;
    localparam int unsigned INDEX_W     = 9;
    localparam int unsigned DATA_W      = 8;

    // Register selectors on the register link
    localparam logic [1:0] SEL_INDEX_LOW  = 2'h0;
    localparam logic [1:0] SEL_INDEX_HIGH = 2'h1;
    localparam logic [1:0] SEL_BUFFER     = 2'h2;
    localparam logic [1:0] SEL_CONTROL    = 2'h3;

    // Control register fields
    localparam int unsigned CTL_READ_STROBE  = 0;
    localparam int unsigned CTL_WRITE_STROBE = 1;
    localparam int unsigned CTL_MASTER_WE    = 2;
    localparam int unsigned CTL_READY_IRQ_EN = 3;
    localparam logic [7:0]  CTL_RESET        = 8'h00;

    // Timing
    localparam int unsigned MWE_WINDOW_CYCLES = 4;
    localparam int unsigned WRITE_STALL       = 2;
    localparam int unsigned READ_STALL        = 4;
    localparam int unsigned PROG_OSC_CYCLES   = 67584;
    localparam logic [2:0]  STALL_NONE        = 3'h0;

    // APB map of the controller's own registers (byte addresses)
    localparam logic [7:0] APB_CMD     = 8'h00;
    localparam logic [7:0] APB_ADDR    = 8'h04;
    localparam logic [7:0] APB_WDATA   = 8'h08;
    localparam logic [7:0] APB_STATUS  = 8'h0c;
    localparam logic [7:0] APB_RDATA   = 8'h10;
    localparam logic [7:0] APB_GLOBAL  = 8'h14;
    localparam logic [31:0] APB_ERR_VAL = 32'hdead0000;

    // Controller commands written to APB_CMD
    localparam logic [1:0] CMD_READ_BYTE  = 2'h1;
    localparam logic [1:0] CMD_WRITE_BYTE = 2'h2;
    localparam logic [1:0] CMD_SET_IRQEN  = 2'h3;
endpackage : nvb_pkg

// File: design/nvb_link_if.sv
/*
 * Register link between a core-side controller and the nonvolatile
 * byte-access device. One register access per cycle, single clock.
 */
interface nvb_link_if;
    logic       wrEn;          // Register write strobe
    logic       rdEn;          // Register read strobe
    logic [1:0] sel;           // Register selector
    logic [7:0] wrData;        // Write byte
    logic [7:0] rdData;        // Read byte, combinational from device
    logic       stall;         // Core halted
    logic       globalIrqEn;   // Core global interrupt enable
    logic       selfProgBusy;  // Flash self-programming in progress
    logic       readyIrq;      // Level ready interrupt

    modport device (input wrEn, input rdEn, input sel, input wrData, output rdData,
                    output stall, input globalIrqEn, input selfProgBusy,
                    output readyIrq);
    modport core (output wrEn, output rdEn, output sel, output wrData, input rdData,
                  input stall, output globalIrqEn, output selfProgBusy,
                  input readyIrq);
endinterface : nvb_link_if

// File: design/nvb_device.sv
/*
 * Nonvolatile byte-access device: index, data and control registers over a
 * 512-byte flip-flop array, with timed programming and core stalls.
 * Assumes the core issues at most one register access per cycle.
 */
// Function
// - 9-bit linear index, bytes 0 to 511
// - Unused index and control bits read zero
// - Index undefined at reset; software loads it
// - Data register sources writes, receives reads
// - Ready interrupt gated by enable and global
// - Ready interrupt is level while strobe zero
// - Strobe within four cycles of master starts write
// - Strobe without master enable is ignored
// - Master enable self-clears after four cycles
// - Software follows the timed write sequence
// - No array write starts during flash programming
// - Software masks interrupts across write sequence; controller keeps globalIrqEn as set over APB
// - Hardware clears strobe when programming ends
// - Write start stalls core two cycles
// - Read strobe loads data, stalls four
// - Busy blocks reads and index changes
// - Write lasts 67584 oscillator cycles
module nvb_device #(
    parameter int unsigned PROG_CYCLES = nvb_pkg::PROG_OSC_CYCLES
) (
    input  wire logic   clk,
    input  wire logic   arst_n,
    input  wire logic   oscTick,
    nvb_link_if.device  link
);
    logic [7:0]  array_mem [nvb_pkg::ARRAY_BYTES];
    logic [8:0]  index_reg;
    logic [7:0]  buffer_reg;
    logic        irqEn_reg;
    logic        mwe_reg;
    logic [2:0]  mweCnt_reg;
    logic        busy_reg;
    logic [16:0] progCnt_reg;
    logic [2:0]  stall_reg;
    logic        irq_reg;
    logic [8:0]  progIndex_reg;
    logic [7:0]  progData_reg;

    // Register access decode
    wire wrLow   = link.wrEn && link.sel == nvb_pkg::SEL_INDEX_LOW;
    wire wrHigh  = link.wrEn && link.sel == nvb_pkg::SEL_INDEX_HIGH;
    wire wrBuf   = link.wrEn && link.sel == nvb_pkg::SEL_BUFFER;
    wire wrCtl   = link.wrEn && link.sel == nvb_pkg::SEL_CONTROL;
    wire wStrobe = wrCtl && link.wrData[nvb_pkg::CTL_WRITE_STROBE];
    wire rStrobe = wrCtl && link.wrData[nvb_pkg::CTL_READ_STROBE];
    wire mweSet  = wrCtl && link.wrData[nvb_pkg::CTL_MASTER_WE];
    // Start needs an armed master enable, idle array, idle flash
    wire startWr = wStrobe && mwe_reg && !busy_reg && !link.selfProgBusy;
    wire doRead  = rStrobe && !busy_reg && !startWr;
    wire progEnd = busy_reg && oscTick && progCnt_reg == 17'(PROG_CYCLES - 1);

    // Read mux; reserved bits return zero
    wire [7:0] ctlView = {4'h0, irqEn_reg, mwe_reg, busy_reg, 1'b0};
    assign link.rdData = link.sel == nvb_pkg::SEL_INDEX_LOW  ? index_reg[7:0] :
                         link.sel == nvb_pkg::SEL_INDEX_HIGH ? {7'h00, index_reg[8]} :
                         link.sel == nvb_pkg::SEL_BUFFER     ? buffer_reg : ctlView;
    assign link.stall    = stall_reg != nvb_pkg::STALL_NONE;
    assign link.readyIrq = irq_reg;

    // Index register: no reset value, frozen while busy
    always_ff @(posedge clk)
    begin
        if (wrLow && !busy_reg)
            index_reg[7:0] <= link.wrData;
        if (wrHigh && !busy_reg)
            index_reg[8] <= link.wrData[0];
    end

    // Data buffer: written by software or filled by a read
    always_ff @(posedge clk)
    begin
        if (doRead)
            buffer_reg <= array_mem[index_reg];
        else if (wrBuf)
            buffer_reg <= link.wrData;
    end

    // Array store at the end of programming
    always_ff @(posedge clk)
    begin
        if (progEnd)
            array_mem[progIndex_reg] <= progData_reg;
    end

    // Control, master window, programming timer, stalls
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irqEn_reg     <= 1'b0;
            mwe_reg       <= 1'b0;
            mweCnt_reg    <= 3'h0;
            busy_reg      <= 1'b0;
            progCnt_reg   <= 17'h0;
            stall_reg     <= nvb_pkg::STALL_NONE;
            irq_reg       <= 1'b0;
            progIndex_reg <= 9'h000;
            progData_reg  <= 8'h00;
        end
        else
        begin
            if (wrCtl)
                irqEn_reg <= link.wrData[nvb_pkg::CTL_READY_IRQ_EN];
            if (mweSet && !wStrobe)
            begin
                mwe_reg    <= 1'b1;
                mweCnt_reg <= 3'(nvb_pkg::MWE_WINDOW_CYCLES);
            end
            else if (startWr || mweCnt_reg == 3'h1)
            begin
                mwe_reg    <= 1'b0;
                mweCnt_reg <= 3'h0;
            end
            else if (mweCnt_reg != 3'h0)
                mweCnt_reg <= mweCnt_reg - 3'h1;
            if (startWr)
            begin
                busy_reg      <= 1'b1;
                progCnt_reg   <= 17'h0;
                progIndex_reg <= index_reg;
                progData_reg  <= buffer_reg;
            end
            else if (progEnd)
                busy_reg <= 1'b0;
            else if (busy_reg && oscTick)
                progCnt_reg <= progCnt_reg + 17'h1;
            if (startWr)
                stall_reg <= 3'(nvb_pkg::WRITE_STALL);
            else if (doRead)
                stall_reg <= 3'(nvb_pkg::READ_STALL);
            else if (stall_reg != nvb_pkg::STALL_NONE)
                stall_reg <= stall_reg - 3'h1;
            // Level request while idle and enabled
            irq_reg <= irqEn_reg && link.globalIrqEn && !busy_reg && !startWr;
        end
    end
endmodule : nvb_device

// File: design/nvb_core_ctrl.sv
/*
 * Core-side controller: takes byte read/write commands over APB and runs
 * the register sequences on the link. Assumes APB and link share clk.
 */
module nvb_core_ctrl (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        flashBusy,
    nvb_link_if.core         link
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_POLL = 3'b001, ST_IDXL = 3'b010, ST_IDXH = 3'b011,
        ST_DATA = 3'b100, ST_MWE  = 3'b101, ST_GO   = 3'b110, ST_FETCH = 3'b111
    } nvb_state_t;

    nvb_state_t state_reg;
    logic [1:0] cmd_reg;
    logic [8:0] addr_reg;
    logic [7:0] wdata_reg, rdata_reg;
    logic       gie_reg, irqEn_reg, done_reg;
    logic       wrEn_reg, rdEn_reg;
    logic [1:0] sel_reg;
    logic [7:0] wrData_reg;

    wire access = psel && penable;
    wire apbWr  = access && pwrite;
    wire idle   = state_reg == ST_IDLE;
    wire [31:0] rdMux = paddr == nvb_pkg::APB_ADDR   ? {23'h0, addr_reg} :
                        paddr == nvb_pkg::APB_WDATA  ? {24'h0, wdata_reg} :
                        paddr == nvb_pkg::APB_STATUS ? {29'h0, link.readyIrq, done_reg, !idle} :
                        paddr == nvb_pkg::APB_RDATA  ? {24'h0, rdata_reg} :
                        paddr == nvb_pkg::APB_GLOBAL ? {31'h0, gie_reg} :
                        paddr == nvb_pkg::APB_CMD    ? 32'h0 : nvb_pkg::APB_ERR_VAL;
    wire badAddr = rdMux == nvb_pkg::APB_ERR_VAL;

    assign link.wrEn         = wrEn_reg;
    assign link.rdEn         = rdEn_reg;
    assign link.sel          = sel_reg;
    assign link.wrData       = wrData_reg;
    assign link.globalIrqEn  = gie_reg;
    assign link.selfProgBusy = flashBusy;

    // APB slave: one-cycle access phase
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && badAddr;
            prdata  <= (psel && !penable && !pwrite && !badAddr) ? rdMux : 32'h0;
        end
    end

    // Sequencer: poll busy, load index and data, arm, strobe
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg  <= ST_IDLE;
            cmd_reg    <= 2'h0;
            addr_reg   <= 9'h000;
            wdata_reg  <= 8'h00;
            rdata_reg  <= 8'h00;
            gie_reg    <= 1'b0;
            irqEn_reg  <= 1'b0;
            done_reg   <= 1'b0;
            wrEn_reg   <= 1'b0;
            rdEn_reg   <= 1'b0;
            sel_reg    <= nvb_pkg::SEL_CONTROL;
            wrData_reg <= 8'h00;
        end
        else
        begin
            wrEn_reg <= 1'b0;
            rdEn_reg <= 1'b0;
            if (apbWr && pready && paddr == nvb_pkg::APB_ADDR && idle)
                addr_reg <= pwdata[8:0];
            if (apbWr && pready && paddr == nvb_pkg::APB_WDATA && idle)
                wdata_reg <= pwdata[7:0];
            if (apbWr && pready && paddr == nvb_pkg::APB_GLOBAL)
                gie_reg <= pwdata[0];
            unique case (state_reg)
                ST_IDLE:
                    if (apbWr && pready && paddr == nvb_pkg::APB_CMD)
                    begin
                        cmd_reg  <= pwdata[1:0];
                        irqEn_reg <= pwdata[1:0] == nvb_pkg::CMD_SET_IRQEN ? pwdata[4]
                                                                            : irqEn_reg;
                        done_reg <= 1'b0;
                        sel_reg  <= nvb_pkg::SEL_CONTROL;
                        state_reg <= ST_POLL;
                    end
                ST_POLL:   // Wait for write strobe and flash programming to clear
                    if (!link.rdData[nvb_pkg::CTL_WRITE_STROBE] && !flashBusy && !link.stall)
                    begin
                        wrEn_reg   <= 1'b1;
                        sel_reg    <= nvb_pkg::SEL_INDEX_LOW;
                        wrData_reg <= addr_reg[7:0];
                        state_reg  <= ST_IDXL;
                    end
                ST_IDXL:
                begin
                    wrEn_reg   <= 1'b1;
                    sel_reg    <= nvb_pkg::SEL_INDEX_HIGH;
                    wrData_reg <= {7'h00, addr_reg[8]};
                    state_reg  <= ST_IDXH;
                end
                ST_IDXH:
                begin
                    wrEn_reg   <= 1'b1;
                    sel_reg    <= cmd_reg == nvb_pkg::CMD_WRITE_BYTE ? nvb_pkg::SEL_BUFFER
                                                                     : nvb_pkg::SEL_CONTROL;
                    wrData_reg <= cmd_reg == nvb_pkg::CMD_WRITE_BYTE ? wdata_reg :
                                  cmd_reg == nvb_pkg::CMD_READ_BYTE  ? {4'h0, irqEn_reg, 3'h1}
                                                                     : {4'h0, irqEn_reg, 3'h0};
                    state_reg  <= cmd_reg == nvb_pkg::CMD_WRITE_BYTE ? ST_DATA : ST_FETCH;
                end
                ST_DATA:   // Arm master enable with strobe zero
                begin
                    wrEn_reg   <= 1'b1;
                    sel_reg    <= nvb_pkg::SEL_CONTROL;
                    wrData_reg <= {4'h0, irqEn_reg, 3'h4};
                    state_reg  <= ST_MWE;
                end
                ST_MWE:    // Strobe the next cycle, inside the window
                begin
                    wrEn_reg   <= 1'b1;
                    wrData_reg <= {4'h0, irqEn_reg, 3'h6};
                    state_reg  <= ST_GO;
                end
                ST_GO:
                begin
                    done_reg  <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                ST_FETCH:  // Let the strobe land and its stall end, then read the buffer
                    if (!link.stall && !wrEn_reg)
                    begin
                        if (sel_reg != nvb_pkg::SEL_BUFFER)
                            sel_reg <= nvb_pkg::SEL_BUFFER;
                        else
                        begin
                            rdEn_reg  <= 1'b1;
                            state_reg <= ST_GO;
                            rdata_reg <= link.rdData;
                        end
                    end
            endcase
        end
    end
endmodule : nvb_core_ctrl

// File: tb/nvb_link_chk.sv
/* Checker for the link between the core controller and the byte device.
   Assumes it watches the one link that joins the two design ends on clk. */
module nvb_link_chk (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic       wrEn,
    input wire logic       rdEn,
    input wire logic [1:0] sel,
    input wire logic [7:0] wrData,
    input wire logic [7:0] rdData,
    input wire logic       stall,
    input wire logic       globalIrqEn,
    input wire logic       selfProgBusy,
    input wire logic       readyIrq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // Control writes decoded from the link
    wire ctlWr   = wrEn && sel == 2'h3;
    wire armWr   = ctlWr && wrData[2:0] == 3'h4;
    wire readGo  = ctlWr && wrData[2:0] == 3'h1 && !rdData[1];
    wire startGo = ctlWr && wrData[2:0] == 3'h6 && !rdData[1] && !selfProgBusy;

    a_ctl_upper_zero: assert property (sel == 2'h3 |-> rdData[7:4] == 4'h0)
        else $error("control upper bits not zero");
    a_idx_high_zero: assert property (sel == 2'h1 |-> rdData[7:1] == 7'h00)
        else $error("index high upper bits not zero");
    a_write_stall_two: assert property (startGo && $past(armWr) |=> stall [*2] ##1 !stall)
        else $error("write start stall length wrong");
    a_read_stall_four: assert property (readGo |=> stall [*4] ##1 !stall)
        else $error("read stall length wrong");
    a_strobe_busy: assert property (startGo && $past(armWr) |=> sel != 2'h3 || rdData[1])
        else $error("write strobe not set after start");
    a_master_expires: assert property (armWr |-> ##5 (sel != 2'h3 || !rdData[2]))
        else $error("master enable did not clear");
    a_stall_has_cause: assert property ($rose(stall) |-> $past(ctlWr))
        else $error("stall without control write");
    a_irq_level: assert property (sel == 2'h3 ##1 (sel == 2'h3 && $stable(rdData)
        && $stable(globalIrqEn)) |-> readyIrq == (rdData[3] && !rdData[1] && globalIrqEn))
        else $error("ready interrupt level wrong");
    a_irq_global_off: assert property (!globalIrqEn [*2] |-> !readyIrq)
        else $error("ready interrupt with global enable off");

    c_write_start: cover property (startGo);
    c_read_start: cover property (readGo);
    c_irq_rise: cover property ($rose(readyIrq));
endmodule : nvb_link_chk

// File: tb/tb.sv
/* Testbench: APB commands into the controller joined to one device, and a
   second device driven straight on its link. Assumes a 125 MHz clock. */
`define CHK(w, x, g) begin comparisons++; if ((g) !== (x)) begin errors++; \
    $display("wrong value %s expected %0h seen %0h", w, x, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, flashBusy = 1'b0, oscTick = 1'b0, pready, pslverr, e;
    logic [7:0]  paddr = 8'h00, r;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [8:0]  idx [3] = '{9'h000, 9'h155, 9'h1ff};
    logic [7:0]  val [3] = '{8'h5a, 8'hc3, 8'h81};
    int          errors = 0;
    int          comparisons = 0;
    nvb_link_if lnk ();
    nvb_link_if lnk2 ();

    // Clock and a half-rate oscillator tick
    always #4 clk = ~clk;
    always @(posedge clk) oscTick <= ~oscTick;

    nvb_core_ctrl i_nvb_core_ctrl (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flashBusy(flashBusy), .link(lnk.core));
    nvb_device #(.PROG_CYCLES(8)) i_nvb_device (.clk(clk), .arst_n(arst_n),
        .oscTick(oscTick), .link(lnk.device));
    nvb_device #(.PROG_CYCLES(8)) i_nvb_device_b (.clk(clk), .arst_n(arst_n),
        .oscTick(oscTick), .link(lnk2.device));
    nvb_link_chk i_nvb_link_chk (.clk(clk), .arst_n(arst_n), .wrEn(lnk.wrEn), .rdEn(lnk.rdEn),
        .sel(lnk.sel), .wrData(lnk.wrData), .rdData(lnk.rdData), .stall(lnk.stall),
        .globalIrqEn(lnk.globalIrqEn), .selfProgBusy(lnk.selfProgBusy),
        .readyIrq(lnk.readyIrq));

    // Verdict and end of run
    task conclude;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude

    // One APB transfer; result in q and e
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 64)
        begin
            errors++;
            conclude();
        end
    endtask : apb

    // Poll status until the command is done and idle
    task waitDone;
        int n;
        n = 0;
        do
        begin
            apb(1'b0, nvb_pkg::APB_STATUS, 32'h0);
            n++;
        end while (!(q[1] === 1'b1 && q[0] === 1'b0) && n < 64);
        if (n >= 64)
        begin
            errors++;
            conclude();
        end
    endtask : waitDone

    // Byte commands through the controller
    task nvCmd(input logic [1:0] c, input logic [8:0] i, input logic [7:0] d);
        apb(1'b1, nvb_pkg::APB_ADDR, {23'h0, i});
        apb(1'b1, nvb_pkg::APB_WDATA, {24'h0, d});
        apb(1'b1, nvb_pkg::APB_CMD, {30'h0, c});
        waitDone();
        apb(1'b0, nvb_pkg::APB_RDATA, 32'h0);
    endtask : nvCmd

    // Direct link access to the second device
    task lw(input logic [1:0] s, input logic [7:0] d);
        @(posedge clk);
        lnk2.wrEn <= 1'b1;
        lnk2.sel <= s;
        lnk2.wrData <= d;
        @(posedge clk);
        lnk2.wrEn <= 1'b0;
    endtask : lw
    task lr(input logic [1:0] s);
        @(posedge clk);
        lnk2.sel <= s;
        @(posedge clk);
        #1 r = lnk2.rdData;
    endtask : lr

    // Main sequence
    initial
    begin
        lnk2.wrEn = 1'b0;
        lnk2.rdEn = 1'b0;
        lnk2.sel = nvb_pkg::SEL_CONTROL;
        lnk2.wrData = 8'h00;
        lnk2.globalIrqEn = 1'b1;
        lnk2.selfProgBusy = 1'b0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        lr(nvb_pkg::SEL_CONTROL);
        `CHK("ctl reset", nvb_pkg::CTL_RESET, r)
        lw(nvb_pkg::SEL_INDEX_HIGH, 8'hff);
        lr(nvb_pkg::SEL_INDEX_HIGH);
        `CHK("idx high", 8'h01, r)
        lw(nvb_pkg::SEL_INDEX_LOW, 8'h05);
        lw(nvb_pkg::SEL_INDEX_HIGH, 8'h00);
        lw(nvb_pkg::SEL_BUFFER, 8'h3c);
        lw(nvb_pkg::SEL_CONTROL, 8'h0c);
        lw(nvb_pkg::SEL_CONTROL, 8'h0a);
        lr(nvb_pkg::SEL_CONTROL);
        `CHK("strobe busy", 1'b1, r[1])
        `CHK("irq busy", 1'b0, lnk2.readyIrq)
        lw(nvb_pkg::SEL_INDEX_LOW, 8'h07);
        lw(nvb_pkg::SEL_CONTROL, 8'h09);
        lr(nvb_pkg::SEL_INDEX_LOW);
        `CHK("idx frozen", 8'h05, r)
        lr(nvb_pkg::SEL_CONTROL);
        for (int n = 0; n < 64 && r[1] !== 1'b0; n++)
            lr(nvb_pkg::SEL_CONTROL);
        `CHK("strobe cleared", 1'b0, r[1])
        lr(nvb_pkg::SEL_CONTROL);
        `CHK("irq ready", 1'b1, lnk2.readyIrq)
        lw(nvb_pkg::SEL_BUFFER, 8'ha5);
        lw(nvb_pkg::SEL_CONTROL, 8'h02);
        lr(nvb_pkg::SEL_CONTROL);
        `CHK("no master", 8'h00, r)
        lw(nvb_pkg::SEL_CONTROL, 8'h04);
        repeat (5) @(posedge clk);
        lw(nvb_pkg::SEL_CONTROL, 8'h06);
        lr(nvb_pkg::SEL_CONTROL);
        `CHK("master expired", 2'h0, r[2:1])
        lnk2.selfProgBusy <= 1'b1;
        lw(nvb_pkg::SEL_CONTROL, 8'h04);
        lw(nvb_pkg::SEL_CONTROL, 8'h06);
        lr(nvb_pkg::SEL_CONTROL);
        `CHK("flash blocks", 1'b0, r[1])
        lnk2.selfProgBusy <= 1'b0;
        lw(nvb_pkg::SEL_CONTROL, 8'h01);
        lr(nvb_pkg::SEL_BUFFER);
        `CHK("read back", 8'h3c, r)
        // Controller side: interrupt enable, writes, reads
        apb(1'b1, nvb_pkg::APB_GLOBAL, 32'h1);
        nvCmd(nvb_pkg::CMD_SET_IRQEN, 9'h000, 8'h00);
        apb(1'b1, nvb_pkg::APB_CMD, 32'h13);
        waitDone();
        apb(1'b0, nvb_pkg::APB_STATUS, 32'h0);
        `CHK("status irq", 1'b1, q[2])
        for (int k = 0; k < 3; k++)
            nvCmd(nvb_pkg::CMD_WRITE_BYTE, idx[k], val[k]);
        apb(1'b0, nvb_pkg::APB_STATUS, 32'h0);
        `CHK("irq in write", 1'b0, q[2])
        for (int k = 0; k < 3; k++)
        begin
            nvCmd(nvb_pkg::CMD_READ_BYTE, idx[k], 8'h00);
            `CHK("array byte", val[k], q[7:0])
        end
        flashBusy <= 1'b1;
        apb(1'b1, nvb_pkg::APB_ADDR, 32'h2);
        apb(1'b1, nvb_pkg::APB_WDATA, 32'h77);
        apb(1'b1, nvb_pkg::APB_CMD, 32'h2);
        repeat (40) @(posedge clk);
        apb(1'b0, nvb_pkg::APB_STATUS, 32'h0);
        `CHK("held by flash", 1'b0, q[1])
        flashBusy <= 1'b0;
        waitDone();
        nvCmd(nvb_pkg::CMD_READ_BYTE, 9'h002, 8'h00);
        `CHK("after flash", 8'h77, q[7:0])
        apb(1'b0, 8'h18, 32'h0);
        `CHK("unmapped err", 1'b1, e)
        `CHK("unmapped data", 32'h0, q)
        conclude();
    end
endmodule : tb
